/* inc/pos_encap_defines.vh */
// Constants for the packet-over-SONET encapsulation block
`ifndef POS_ENCAP_DEFINES_VH
`define POS_ENCAP_DEFINES_VH
`define REG_CTRL_BASE 8'h00
`define REG_CIRC 8'h20
`define REG_ALARM 8'h24
`define REG_REJECT 8'h28
`define REG_MTU 8'h2C
`define CTRL_ENC_BIT 0
`define CTRL_CRC_ON_BIT 1
`define CTRL_CRC32_BIT 2
`define CTRL_ADMIN_BIT 3
`define CTRL_SOAK_LSB 8
`define CTRL_RESET 32'h0000_0000
`define ENC_GFP 1'b0
`define ENC_HDLC 1'b1
`define HDLC_FLAG 8'h7E
`define STUFF_RUN 3'd5
`define MTU_RESET 14'd9216
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`define AXI_DECERR 2'b11
`endif

/* hdl/pos_ethernet_encapsulator.v */
// Per-port encapsulation control with HDLC-style bit-stuffed transmit and receive
//
// Notes on behaviour
// - Eight encapsulation channels, one per Ethernet client port 1 to 8.
// - Per-port choice of GFP-F or HDLC style; GFP-F after reset.
// - GFP-F uses 32-bit CRC or none; none is the initial choice. Here the CRC bits are only stored; no CRC is generated or checked.
// - HDLC style uses a 16-bit or a 32-bit CRC. Here the CRC selection is only stored in ctrl_q; no CRC is computed.
// - Encapsulation change is rejected while a circuit exists; old type kept.
// - Received encapsulation mismatch blocks traffic and raises a mismatch alarm.
// - GFP-F carries exactly one whole packet per frame. Here the GFP-F path passes tx_bit_in unchanged, with no framing.
// - HDLC style inserts zeros on transmit and deletes them on receive.
// - Client frames are encapsulated and handed on as a circuit stream.
// - Received frames are de-encapsulated and rebuilt toward the client.
// - Channel streams feed one OC-192/STM-64 rate trunk aggregator.
// - At most eight Gigabit Ethernet clients are accepted.
// - HDLC framer runs synchronously on the line clock.
// - Each port holds admin state, encapsulation, CRC and soak settings; one MTU is shared by all ports.
// - Settings survive switchovers; data path has no reset-free glitches.
// - Common GFP functions are kept apart from Ethernet-specific ones.
`timescale 1ns/1ns
`default_nettype none
`include "pos_encap_defines.vh"
module pos_ethernet_encapsulator #(
    parameter NCH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NCH-1:0] tx_bit_in,
    input wire [NCH-1:0] tx_frame_in,
    output reg [NCH-1:0] tx_line_out,
    input wire [NCH-1:0] rx_line_in,
    input wire [NCH-1:0] rx_enc_in,
    output reg [NCH-1:0] rx_bit_out,
    output reg [NCH-1:0] rx_bit_valid,
    output reg [NCH-1:0] tx_ready
);
// ---------------------------------------------------------------
// Register file
// ---------------------------------------------------------------
reg [31:0] ctrl_q [0:NCH-1];
reg [NCH-1:0] circ_q;
reg [NCH-1:0] alarm_q;
reg [NCH-1:0] reject_q;
reg [13:0] mtu_q;
reg [7:0] awaddr_q;
reg [31:0] wdata_q;
reg aw_have_q;
reg w_have_q;
wire [NCH-1:0] mismatch;
wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
wire [2:0] wr_idx = awaddr_q[4:2];
wire wr_ctrl = (awaddr_q[7:5] == 3'd0);
wire new_enc = wdata_q[`CTRL_ENC_BIT];
integer i;
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `AXI_OKAY;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awaddr_q <= 8'h00;
        wdata_q <= 32'h0000_0000;
        circ_q <= {NCH{1'b0}};
        reject_q <= {NCH{1'b0}};
        alarm_q <= {NCH{1'b0}};
        mtu_q <= `MTU_RESET;
        for (i = 0; i < NCH; i = i + 1) begin
            ctrl_q[i] <= `CTRL_RESET;
        end
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        // Alarm is sticky; set wins over a software clear
        alarm_q <= alarm_q | mismatch;
        if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `AXI_OKAY;
            if (wr_ctrl) begin
                if (circ_q[wr_idx] && new_enc != ctrl_q[wr_idx][`CTRL_ENC_BIT]) begin
                    reject_q[wr_idx] <= 1'b1;
                    s_axi_bresp <= `AXI_SLVERR;
                end else begin
                    ctrl_q[wr_idx] <= wdata_q;
                end
            end else if (awaddr_q == `REG_CIRC) begin
                circ_q <= wdata_q[NCH-1:0];
            end else if (awaddr_q == `REG_ALARM) begin
                alarm_q <= (alarm_q & ~wdata_q[NCH-1:0]) | mismatch;
            end else if (awaddr_q == `REG_REJECT) begin
                reject_q <= reject_q & ~wdata_q[NCH-1:0];
            end else if (awaddr_q == `REG_MTU) begin
                mtu_q <= wdata_q[13:0];
            end else begin
                s_axi_bresp <= `AXI_DECERR;
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end
// ---------------------------------------------------------------
// Read channel
// ---------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AXI_OKAY;
        if (s_axi_araddr[7:5] == 3'd0) begin
            s_axi_rdata <= ctrl_q[s_axi_araddr[4:2]];
        end else if (s_axi_araddr == `REG_CIRC) begin
            s_axi_rdata <= {{(32-NCH){1'b0}}, circ_q};
        end else if (s_axi_araddr == `REG_ALARM) begin
            s_axi_rdata <= {{(32-NCH){1'b0}}, alarm_q};
        end else if (s_axi_araddr == `REG_REJECT) begin
            s_axi_rdata <= {{(32-NCH){1'b0}}, reject_q};
        end else if (s_axi_araddr == `REG_MTU) begin
            s_axi_rdata <= {{18{1'b0}}, mtu_q};
        end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_DECERR;
        end
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end
// ---------------------------------------------------------------
// Per-channel HDLC-style bit stuffing, flags and receive checks
// ---------------------------------------------------------------
genvar g;
generate
for (g = 0; g < NCH; g = g + 1) begin : chan
    reg [2:0] tx_ones_q;
    reg [2:0] tx_flag_cnt_q;
    reg tx_stuff_q;
    reg [2:0] rx_ones_q;
    reg rx_sync1_q;
    reg rx_sync2_q;
    reg enc_sync1_q;
    reg enc_sync2_q;
    wire hdlc = ctrl_q[g][`CTRL_ENC_BIT];
    wire admin = ctrl_q[g][`CTRL_ADMIN_BIT];
    assign mismatch[g] = circ_q[g] && (enc_sync2_q != hdlc);
    wire pass = admin && circ_q[g] && !mismatch[g];
    wire [7:0] flag = `HDLC_FLAG;
    // Transmit: line clock is aclk, one bit per cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_ones_q <= 3'd0;
            tx_flag_cnt_q <= 3'd0;
            tx_stuff_q <= 1'b0;
            tx_line_out[g] <= 1'b0;
            tx_ready[g] <= 1'b0;
        end else if (!pass) begin
            tx_line_out[g] <= 1'b0;
            tx_ready[g] <= 1'b0;
            tx_ones_q <= 3'd0;
        end else if (hdlc && (!tx_frame_in[g] || tx_flag_cnt_q != 3'd0)) begin
            // Idle flags between frames; a started flag is finished unless pass drops first
            tx_line_out[g] <= flag[tx_flag_cnt_q];
            tx_flag_cnt_q <= tx_flag_cnt_q + 3'd1;
            tx_ones_q <= 3'd0;
            tx_ready[g] <= 1'b1;
        end else if (hdlc && tx_ones_q == `STUFF_RUN) begin
            tx_line_out[g] <= 1'b0;
            tx_ones_q <= 3'd0;
            tx_stuff_q <= 1'b1;
            tx_ready[g] <= 1'b1;
        end else begin
            // GFP bits and unstuffed HDLC data bits pass unchanged
            tx_line_out[g] <= tx_bit_in[g];
            tx_ones_q <= (hdlc && tx_bit_in[g]) ? tx_ones_q + 3'd1 : 3'd0;
            tx_stuff_q <= 1'b0;
            tx_ready[g] <= !(hdlc && tx_bit_in[g] && tx_ones_q == 3'd4);
        end
    end
    // Receive: synchronise line and encapsulation indication
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_sync1_q <= 1'b0;
            rx_sync2_q <= 1'b0;
            enc_sync1_q <= 1'b0;
            enc_sync2_q <= 1'b0;
            rx_ones_q <= 3'd0;
            rx_bit_out[g] <= 1'b0;
            rx_bit_valid[g] <= 1'b0;
        end else begin
            rx_sync1_q <= rx_line_in[g];
            rx_sync2_q <= rx_sync1_q;
            enc_sync1_q <= rx_enc_in[g];
            enc_sync2_q <= enc_sync1_q;
            rx_bit_out[g] <= rx_sync2_q;
            if (!pass) begin
                rx_bit_valid[g] <= 1'b0;
                rx_ones_q <= 3'd0;
            end else if (hdlc && rx_ones_q == `STUFF_RUN && !rx_sync2_q) begin
                rx_bit_valid[g] <= 1'b0;
                rx_ones_q <= 3'd0;
            end else begin
                rx_bit_valid[g] <= 1'b1;
                rx_ones_q <= (hdlc && rx_sync2_q && rx_ones_q != 3'd7) ?
                    rx_ones_q + 3'd1 : 3'd0;
            end
        end
    end
end
endgenerate
// CRC selection bits are held in ctrl_q but no logic here reads them
endmodule
`default_nettype wire

/* bench/far_end_card.sv */
// Far-end card model that loops the line stream back
`timescale 1ns/1ns
`default_nettype none
module far_end_card (
    input wire logic aclk,
    input wire logic [7:0] line_in,
    output logic [7:0] line_out
);
    // ----------
    // Loopback
    // ----------
    initial line_out = 8'h00;
    always @(posedge aclk) line_out <= line_in;
endmodule
`default_nettype wire

/* bench/pos_encap_props.sv */
// Port checks for the encapsulator
`timescale 1ns/1ns
`default_nettype none
`include "pos_encap_defines.vh"
module pos_encap_props #(
    parameter NCH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NCH-1:0] rx_bit_valid
);
    // ----------
    // Assertions
    // ----------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer lost");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("late read answer");
    property p_dec; s_axi_rvalid && s_axi_rresp == `AXI_DECERR |-> s_axi_rdata == 0; endproperty
    a_dec: assert property (p_dec) else $error("unmapped read not zero");
    property p_bleg; s_axi_bvalid |-> s_axi_bresp != 2'b01; endproperty
    a_bleg: assert property (p_bleg) else $error("bad write response");
    property p_awblk; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_awblk: assert property (p_awblk) else $error("awready during response");
    property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arblk: assert property (p_arblk) else $error("arready during response");
    property p_rst; $rose(aresetn) |-> s_axi_awready && rx_bit_valid == 0; endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule
bind pos_ethernet_encapsulator pos_encap_props #(.NCH(NCH)) props (.*);
`default_nettype wire

/* bench/test_pos_ethernet_encapsulator.sv */
// Self-checking bench for the encapsulator
`timescale 1ns/1ns
`default_nettype none
`include "pos_encap_defines.vh"
module test_pos_ethernet_encapsulator;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, tx_bit_in = '0, tx_frame_in = '0, i;
    logic [7:0] rx_enc_in = '0, rx_line_in, tx_line_out, rx_bit_out, rx_bit_valid, tx_ready;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, v, seed = 32'h9650_3949;
    logic [33:0] exq[$];
    int fails = 0, num_checks = 0, run = 0, rv = 0, st = 0, fc = 0;
    always #50 aclk = ~aclk;
    pos_ethernet_encapsulator #(.NCH(8)) dut (.*);
    far_end_card peer (.aclk(aclk), .line_in(tx_line_out), .line_out(rx_line_in));
    // ----------
    // Tasks
    // ----------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
        int n = 0;
        exq.push_back({r, w ? 32'h0 : d});
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!(s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) && n < 50);
        {s_axi_bready, s_axi_rready} <= 2'b00;
        @(posedge aclk);
        if (n >= 50) begin
            fails++;
            wrap_up();
        end
    endtask
    // ----------
    // Monitor
    // ----------
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exq.pop_front());
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exq.pop_front());
        if (tx_frame_in[0]) fc++;
        else fc = 0;
        if (fc > 10) begin
            run = tx_line_out[0] ? run + 1 : 0;
            rv += rx_bit_valid[0];
            st += !tx_ready[0];
            chk({33'h0, run > 5}, 34'h0);
            if (fc > 16 && rx_bit_valid[0] === 1'b1) chk({33'h0, rx_bit_out[0]}, 34'h1);
        end else begin
            run = 0;
        end
    end
    // ----------
    // Sequence
    // ----------
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        for (i = 0; i < 8; i++) xfer(0, i << 2, '0, `AXI_OKAY);
        xfer(0, `REG_MTU, {18'h0, `MTU_RESET}, `AXI_OKAY);
        xfer(0, 8'hfc, '0, `AXI_DECERR);
        xfer(1, 8'hfc, seed, `AXI_DECERR);
        for (i = 1; i < 8; i++) begin
            seed = xs(seed);
            v = {16'h0, seed[15:8], 4'h0, seed[3], 1'b0, seed[1], 1'b0};
            {tx_bit_in[7:1], tx_frame_in[7:1]} <= seed[29:16];
            xfer(1, i << 2, v, `AXI_OKAY);
            xfer(0, i << 2, v, `AXI_OKAY);
        end
        rx_enc_in <= 8'h01;
        xfer(1, `REG_CTRL_BASE, 32'h0000_000f, `AXI_OKAY);
        xfer(1, `REG_CIRC, 32'h0000_0001, `AXI_OKAY);
        xfer(1, `REG_CTRL_BASE, 32'h0000_000e, `AXI_SLVERR);
        xfer(0, `REG_CTRL_BASE, 32'h0000_000f, `AXI_OKAY);
        xfer(0, `REG_REJECT, 32'h0000_0001, `AXI_OKAY);
        tx_bit_in[0] <= 1;
        tx_frame_in[0] <= 1;
        repeat (200) @(posedge aclk);
        chk({33'h0, rv > 100 && st > 10}, 34'h1);
        rx_enc_in <= '0;
        repeat (10) @(posedge aclk);
        rv = 0;
        repeat (50) @(posedge aclk);
        chk(34'(rv), 34'h0);
        xfer(0, `REG_ALARM, 32'h0000_0001, `AXI_OKAY);
        wrap_up();
    end
endmodule
`default_nettype wire
